// >>> hdl/sci_pkg.sv
// constants shared by the serial control port ends
package sci_pkg;
	// bus addresses of the register groups
	localparam logic [7:0] BUS_FUNC_WR = 8'hE8;
	localparam logic [7:0] BUS_CS_WR = 8'hE9;
	localparam logic [7:0] BUS_EVT_RD = 8'hEA;
	localparam logic [7:0] BUS_RATE_RD = 8'hEB;
	localparam logic [7:0] BUS_CS_RD = 8'hEC;
	localparam logic [7:0] BUS_PC_RD = 8'hED;
	// command addresses inside the function group
	localparam logic [3:0] CMD_SYSTEM = 4'h0;
	localparam logic [3:0] CMD_IRQ_SEL = 4'h8;
	localparam logic [3:0] CMD_AUX_PORT = 4'hA;
	// bit positions inside the data byte (DI8 is bit 0)
	localparam int SYS_RDDIS_BIT = 1;
	localparam int SYS_SHAPE_BIT = 3;
	localparam int SYS_RXRUN_BIT = 4;
	localparam int SYS_TXRUN_BIT = 5;
	// event source positions (DO8 is bit 0)
	localparam int EVT_FAULT = 0;
	localparam int EVT_NONPCM = 4;
	// frame lengths
	localparam logic [4:0] ADDR_BITS = 5'h08;
	localparam logic [4:0] WORD_BITS = 5'h10;
	// interrupt pulse length in half-fs ticks
	localparam logic [1:0] IRQ_PULSE_TICKS = 2'h2;
	// reset values
	localparam logic [7:0] IRQ_SEL_RST = 8'h00;
	localparam logic [3:0] AUX_OUT_RST = 4'h0;
	// link bit timing of the host, in hclk cycles
	localparam logic [3:0] LINK_HALF_CYC = 4'h8;
	localparam logic [3:0] LINK_BIT_LAST = 4'hF;
	// host register offsets on the AHB-Lite bus
	localparam logic [7:0] REG_BUS_ADDR = 8'h00;
	localparam logic [7:0] REG_WORD = 8'h04;
	localparam logic [7:0] REG_GO = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_READ = 8'h10;
endpackage : sci_pkg

// >>> hdl/sci_if.sv
// four-wire serial control link between host and device
`timescale 1ns/10ps
`default_nettype none
interface sci_if;
	logic serial_shift_clock;
	logic serial_enable;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	logic irq_n;
	logic serial_out_line;
	// floating readback line is pulled high
	assign serial_out_line = serial_out_oe ? serial_out : 1'b1;
	modport dev (
		input serial_shift_clock,
		input serial_enable,
		input serial_in,
		output serial_out,
		output serial_out_oe,
		output irq_n
	);
	modport host (
		output serial_shift_clock,
		output serial_enable,
		output serial_in,
		input serial_out_line,
		input irq_n
	);
endinterface : sci_if
`default_nettype wire

// >>> hdl/sci_sync.sv
// two-flop synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module sci_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic d,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	assign level = s2_reg;
	assign rise = s2_reg & ~s3_reg;
	assign fall = ~s2_reg & s3_reg;
endmodule : sci_sync
`default_nettype wire

// >>> hdl/sci_device.sv
// device end of the serial control port with interrupt and aux port
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sci_device
	import sci_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	sci_if.dev link,
	input wire logic [1:0] chip_addr_strap,
	input wire logic fs2_tick,
	input wire logic receive_fault_flag,
	input wire logic input_activity,
	input wire logic [3:0] rate_code,
	input wire logic [47:0] chanstat,
	input wire logic nonaudio_flag,
	input wire logic burst_info_evt,
	input wire logic slip_evt,
	input wire logic emphasis_flag,
	input wire logic [15:0] burst_pc,
	input wire logic port_direction_sel,
	input wire logic [3:0] aux_port_in,
	output logic [3:0] aux_port_out,
	output logic [3:0] aux_port_oe,
	output logic tx_run,
	output logic rx_run,
	output logic [7:0] cs_wr_byte,
	output logic [3:0] cs_wr_index,
	output logic cs_wr_strobe
);
	logic ck_rise;
	logic ck_fall;
	logic ce_lvl;
	logic ce_rise;
	logic ce_fall;
	logic din_lvl;
	sci_sync u_ck (.hclk(hclk), .hresetn(hresetn), .d(link.serial_shift_clock),
		.level(), .rise(ck_rise), .fall(ck_fall));
	sci_sync u_ce (.hclk(hclk), .hresetn(hresetn), .d(link.serial_enable),
		.level(ce_lvl), .rise(ce_rise), .fall(ce_fall));
	sci_sync u_di (.hclk(hclk), .hresetn(hresetn), .d(link.serial_in),
		.level(din_lvl), .rise(), .fall());

	// pin inputs: strap, direction and aux lines
	logic [6:0] pin_s1_reg;
	logic [6:0] pin_s2_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_reg <= 7'h00;
			pin_s2_reg <= 7'h00;
		end else begin
			pin_s1_reg <= {chip_addr_strap, port_direction_sel, aux_port_in};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	wire [1:0] strap_s = pin_s2_reg[6:5];
	wire dir_in_s = pin_s2_reg[4];
	wire [3:0] aux_in_s = pin_s2_reg[3:0];

	// serial shift state
	logic [7:0] addr_sh_reg;
	logic [15:0] word_sh_reg;
	logic [4:0] bit_cnt_reg;
	logic [15:0] rd_sh_reg;
	logic rd_active_reg;
	wire [7:0] bus_addr = {addr_sh_reg[3:0], addr_sh_reg[7:4]};
	wire [1:0] word_chip = word_sh_reg[1:0];
	wire [1:0] word_rsvd = word_sh_reg[3:2];
	wire [3:0] word_cmd = word_sh_reg[7:4];
	wire [7:0] word_data = word_sh_reg[15:8];
	wire is_func_wr = bus_addr == BUS_FUNC_WR;
	wire is_cs_wr = bus_addr == BUS_CS_WR;
	wire is_evt_rd = bus_addr == BUS_EVT_RD;
	wire is_rate_rd = bus_addr == BUS_RATE_RD;
	wire is_cs_rd = bus_addr == BUS_CS_RD;
	wire is_pc_rd = bus_addr == BUS_PC_RD;
	wire is_read = is_evt_rd | is_rate_rd | is_cs_rd | is_pc_rd;
	wire word_ok = (bit_cnt_reg == WORD_BITS) && (word_chip == strap_s)
		&& (word_rsvd == 2'h0);
	wire commit = ce_fall & word_ok;
	wire func_commit = commit & is_func_wr;
	wire evt_read = ce_rise & is_evt_rd;

	// configuration
	logic irq_shape_sel_reg;
	logic readout_disable_reg;
	logic [7:0] irq_sel_reg;
	logic [3:0] aux_val_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_shape_sel_reg <= 1'b0;
			readout_disable_reg <= 1'b0;
			tx_run <= 1'b0;
			rx_run <= 1'b0;
			irq_sel_reg <= IRQ_SEL_RST;
			aux_val_reg <= AUX_OUT_RST;
		end else if (func_commit) begin
			if (word_cmd == CMD_SYSTEM) begin
				irq_shape_sel_reg <= word_data[SYS_SHAPE_BIT];
				readout_disable_reg <= word_data[SYS_RDDIS_BIT];
				tx_run <= word_data[SYS_TXRUN_BIT];
				rx_run <= word_data[SYS_RXRUN_BIT];
			end
			if (word_cmd == CMD_IRQ_SEL) begin
				irq_sel_reg <= word_data;
			end
			if (word_cmd == CMD_AUX_PORT) begin
				aux_val_reg <= word_data[7:4];
			end
		end
	end

	// channel-status write group
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cs_wr_byte <= 8'h00;
			cs_wr_index <= 4'h0;
			cs_wr_strobe <= 1'b0;
		end else begin
			cs_wr_strobe <= commit & is_cs_wr;
			if (commit & is_cs_wr) begin
				cs_wr_byte <= word_data;
				cs_wr_index <= word_cmd;
			end
		end
	end

	// event sources
	logic fault_prev_reg;
	logic act_prev_reg;
	logic [3:0] rate_prev_reg;
	logic [47:0] cs_prev_reg;
	logic nonpcm_prev_reg;
	logic emph_prev_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_prev_reg <= 1'b0;
			act_prev_reg <= 1'b0;
			rate_prev_reg <= 4'h0;
			cs_prev_reg <= 48'h0000_0000_0000;
			nonpcm_prev_reg <= 1'b0;
			emph_prev_reg <= 1'b0;
		end else begin
			fault_prev_reg <= receive_fault_flag;
			act_prev_reg <= input_activity;
			rate_prev_reg <= rate_code;
			cs_prev_reg <= chanstat;
			nonpcm_prev_reg <= nonaudio_flag;
			emph_prev_reg <= emphasis_flag;
		end
	end
	wire [7:0] evt_now = {
		emphasis_flag ^ emph_prev_reg,
		slip_evt,
		burst_info_evt,
		nonaudio_flag ^ nonpcm_prev_reg,
		chanstat != cs_prev_reg,
		rate_code != rate_prev_reg,
		input_activity ^ act_prev_reg,
		receive_fault_flag ^ fault_prev_reg
	};
	wire [7:0] evt_hit = evt_now & irq_sel_reg;

	// pending sources, set wins over read clear
	logic [7:0] pend_reg;
	wire [7:0] pend_next = (pend_reg & ~{8{evt_read}}) | evt_hit;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg <= 8'h00;
		end else begin
			pend_reg <= pend_next;
		end
	end

	// pulse shaping on half-fs ticks
	logic pulse_reg;
	logic [1:0] tick_cnt_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_reg <= 1'b0;
			tick_cnt_reg <= 2'h0;
		end else if (|evt_hit) begin
			pulse_reg <= 1'b1;
			tick_cnt_reg <= 2'h0;
		end else if (pulse_reg & fs2_tick) begin
			tick_cnt_reg <= tick_cnt_reg + 2'h1;
			if (tick_cnt_reg == IRQ_PULSE_TICKS - 2'h1) begin
				pulse_reg <= 1'b0;
			end
		end
	end

	logic irq_n_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= irq_shape_sel_reg ? ~pulse_reg : ~(|pend_reg);
		end
	end
	assign link.irq_n = irq_n_reg;

	// readout words
	logic [3:0] aux_cap_reg;
	wire [7:0] evt_bits = {pend_reg[7:5], nonaudio_flag, pend_reg[3:1],
		receive_fault_flag};
	wire [15:0] evt_word = {evt_bits, 8'h00};
	wire [15:0] rate_word = {8'h00, rate_code, aux_cap_reg};
	wire [15:0] rd_word = is_evt_rd ? evt_word :
		is_rate_rd ? rate_word :
		is_cs_rd ? chanstat[15:0] : burst_pc;

	// serial framing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_sh_reg <= 8'h00;
			word_sh_reg <= 16'h0000;
			bit_cnt_reg <= 5'h00;
			rd_sh_reg <= 16'h0000;
			rd_active_reg <= 1'b0;
		end else begin
			if (ce_rise) begin
				bit_cnt_reg <= 5'h00;
				word_sh_reg <= 16'h0000;
				rd_active_reg <= is_read;
				rd_sh_reg <= rd_word;
			end else if (ce_fall) begin
				rd_active_reg <= 1'b0;
			end else if (ck_rise & ~ce_lvl) begin
				addr_sh_reg <= {din_lvl, addr_sh_reg[7:1]};
			end else if (ck_rise & ce_lvl & (bit_cnt_reg != WORD_BITS)) begin
				word_sh_reg <= {din_lvl, word_sh_reg[15:1]};
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
			end else if (ck_fall & ce_lvl & rd_active_reg) begin
				rd_sh_reg <= {1'b0, rd_sh_reg[15:1]};
			end
		end
	end

	logic so_reg;
	logic so_oe_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
		end else begin
			so_reg <= rd_sh_reg[0];
			so_oe_reg <= rd_active_reg & ce_lvl & ~ce_fall & ~readout_disable_reg;
		end
	end
	assign link.serial_out = so_reg;
	assign link.serial_out_oe = so_oe_reg;

	// aux port
	logic [3:0] aux_out_reg;
	logic [3:0] aux_oe_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aux_out_reg <= AUX_OUT_RST;
			aux_oe_reg <= 4'h0;
			aux_cap_reg <= 4'h0;
		end else begin
			aux_out_reg <= aux_val_reg;
			aux_oe_reg <= {4{~dir_in_s}};
			if (dir_in_s) begin
				aux_cap_reg <= aux_in_s;
			end
		end
	end
	assign aux_port_out = aux_out_reg;
	assign aux_port_oe = aux_oe_reg;
endmodule : sci_device
`default_nettype wire

// >>> hdl/sci_host.sv
// host end: AHB-Lite registers driving the four-wire serial link
`timescale 1ns/10ps
`default_nettype none
module sci_host
	import sci_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	sci_if.host link
);
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_ADDR = 5'b00010,
		H_OPEN = 5'b00100,
		H_DATA = 5'b01000,
		H_CLOSE = 5'b10000
	} sci_hstate_t;
	sci_hstate_t state_reg;

	// AHB-Lite slave, one wait state per transfer
	logic dp_reg;
	logic dp_write_reg;
	logic [7:0] dp_addr_reg;
	logic [7:0] bus_addr_reg;
	logic [15:0] word_reg;
	logic [15:0] read_reg;
	logic so_s1_reg;
	logic so_s2_reg;
	logic irq_s1_reg;
	logic irq_s2_reg;
	wire a_valid = hsel & hready & htrans[1];
	wire wr_now = dp_reg & dp_write_reg;
	wire busy = state_reg != H_IDLE;
	wire go = wr_now & (dp_addr_reg == REG_GO) & hwdata[0] & ~busy;
	wire [31:0] status_word = {28'h000_0000, 2'h0, ~irq_s2_reg, busy};
	wire [31:0] rd_mux = (dp_addr_reg == REG_BUS_ADDR) ? {24'h00_0000, bus_addr_reg} :
		(dp_addr_reg == REG_WORD) ? {16'h0000, word_reg} :
		(dp_addr_reg == REG_STATUS) ? status_word :
		(dp_addr_reg == REG_READ) ? {16'h0000, read_reg} : 32'h0000_0000;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else if (a_valid) begin
			dp_reg <= 1'b1;
			dp_write_reg <= hwrite;
			dp_addr_reg <= haddr[7:0];
			hreadyout <= 1'b0;
		end else begin
			dp_reg <= 1'b0;
			hreadyout <= 1'b1;
			if (dp_reg & ~dp_write_reg) begin
				hrdata <= rd_mux;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_addr_reg <= 8'h00;
			word_reg <= 16'h0000;
		end else begin
			if (wr_now & (dp_addr_reg == REG_BUS_ADDR)) begin
				bus_addr_reg <= hwdata[7:0];
			end
			if (wr_now & (dp_addr_reg == REG_WORD)) begin
				word_reg <= hwdata[15:0];
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			so_s1_reg <= 1'b1;
			so_s2_reg <= 1'b1;
			irq_s1_reg <= 1'b1;
			irq_s2_reg <= 1'b1;
		end else begin
			so_s1_reg <= link.serial_out_line;
			so_s2_reg <= so_s1_reg;
			irq_s1_reg <= link.irq_n;
			irq_s2_reg <= irq_s1_reg;
		end
	end

	// serial sequencer, shift clock from a divider
	logic [3:0] ph_reg;
	logic [4:0] bit_cnt_reg;
	logic [23:0] out_sh_reg;
	logic [15:0] in_sh_reg;
	logic sclk_reg;
	logic ce_reg;
	logic sdo_reg;
	wire ph_last = ph_reg == LINK_BIT_LAST;
	wire is_read = (bus_addr_reg >= BUS_EVT_RD) && (bus_addr_reg <= BUS_PC_RD);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= H_IDLE;
			ph_reg <= 4'h0;
			bit_cnt_reg <= 5'h00;
			out_sh_reg <= 24'h00_0000;
			in_sh_reg <= 16'h0000;
			read_reg <= 16'h0000;
			sclk_reg <= 1'b0;
			ce_reg <= 1'b0;
			sdo_reg <= 1'b0;
		end else begin
			ph_reg <= (busy && !ph_last) ? ph_reg + 4'h1 : 4'h0;
			case (state_reg)
				H_IDLE: begin
					sclk_reg <= 1'b0;
					ce_reg <= 1'b0;
					bit_cnt_reg <= 5'h00;
					if (go) begin
						// upper nibble first, then lower, each lsb first
						out_sh_reg <= {word_reg, bus_addr_reg[3:0], bus_addr_reg[7:4]};
						state_reg <= H_ADDR;
					end
				end
				H_ADDR, H_DATA: begin
					sclk_reg <= ph_reg >= LINK_HALF_CYC;
					if (ph_reg == 4'h0) begin
						sdo_reg <= out_sh_reg[0];
					end
					if ((ph_reg == LINK_HALF_CYC) && (state_reg == H_DATA)) begin
						in_sh_reg <= {so_s2_reg, in_sh_reg[15:1]};
					end
					if (ph_last) begin
						out_sh_reg <= {1'b0, out_sh_reg[23:1]};
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if ((state_reg == H_ADDR) && (bit_cnt_reg == ADDR_BITS - 5'h01)) begin
							state_reg <= H_OPEN;
						end
						if ((state_reg == H_DATA) && (bit_cnt_reg == WORD_BITS - 5'h01)) begin
							state_reg <= H_CLOSE;
						end
					end
				end
				H_OPEN: begin
					sclk_reg <= 1'b0;
					ce_reg <= 1'b1;
					bit_cnt_reg <= 5'h00;
					if (ph_last) begin
						state_reg <= H_DATA;
					end
				end
				H_CLOSE: begin
					sclk_reg <= 1'b0;
					if (ph_reg == LINK_HALF_CYC) begin
						ce_reg <= 1'b0;
					end
					if (ph_last) begin
						if (is_read) begin
							read_reg <= in_sh_reg;
						end
						state_reg <= H_IDLE;
					end
				end
				default: begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end
	assign link.serial_shift_clock = sclk_reg;
	assign link.serial_enable = ce_reg;
	assign link.serial_in = sdo_reg;
endmodule : sci_host
`default_nettype wire

// >>> testbench/sci_link_monitor.sv
// assertion checker watching the four-wire serial control link
`timescale 1ns/10ps
`default_nettype none
module sci_link_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic serial_shift_clock,
	input wire logic serial_enable,
	input wire logic serial_in,
	input wire logic serial_out_oe,
	input wire logic irq_n
);
	logic clk_d;
	logic [4:0] n_addr;
	logic [4:0] n_data;
	logic [7:0] sh;
	wire logic sck_rise = serial_shift_clock & ~clk_d;
	wire logic [7:0] bus_addr = {sh[3:0], sh[7:4]};
	wire logic is_rd = (bus_addr >= 8'hEA) && (bus_addr <= 8'hED);

	// counts address and word bits of the current frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_d <= 1'b0;
			n_addr <= 5'h00;
			n_data <= 5'h00;
			sh <= 8'h00;
		end else begin
			clk_d <= serial_shift_clock;
			n_addr <= serial_enable ? 5'h00 : n_addr + {4'h0, sck_rise};
			n_data <= serial_enable ? n_data + {4'h0, sck_rise} : 5'h00;
			sh <= (sck_rise && !serial_enable) ? {serial_in, sh[7:1]} : sh;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_CLK_HIGH: assert property (
		$rose(serial_shift_clock) |-> serial_shift_clock[*8] ##1 !serial_shift_clock)
		else $error("link clock high time wrong");
	AST_CLK_LOW: assert property (
		$fell(serial_shift_clock) |-> !serial_shift_clock[*8])
		else $error("link clock low time too short");
	AST_DATA_STABLE: assert property (
		serial_shift_clock && $past(serial_shift_clock) |-> $stable(serial_in))
		else $error("serial input moved while clock high");
	AST_EN_CLK_LOW: assert property (
		$changed(serial_enable) |-> !serial_shift_clock)
		else $error("enable moved while clock high");
	AST_ADDR_CNT: assert property (
		$rose(serial_enable) |-> n_addr == 5'h08)
		else $error("address phase not eight bits");
	AST_DATA_CNT: assert property (
		$fell(serial_enable) |-> n_data == 5'h10)
		else $error("word phase not sixteen bits");
	AST_ADDR_MAP: assert property (
		$rose(serial_enable) |-> (bus_addr >= 8'hE8) && (bus_addr <= 8'hED))
		else $error("bus address outside the group map");
	AST_OE_START: assert property (
		$rose(serial_out_oe) |-> serial_enable && is_rd)
		else $error("readback driven outside a read frame");
	AST_OE_STOP: assert property (
		$fell(serial_enable) |-> ##[1:6] !serial_out_oe)
		else $error("readback still driven after enable fell");
	AST_OE_IDLE: assert property (
		!serial_enable[*8] |-> !serial_out_oe)
		else $error("readback driven while enable low");
	AST_IRQ_RESET: assert property (
		$rose(hresetn) |-> irq_n)
		else $error("interrupt not idle after reset");
endmodule : sci_link_monitor
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the serial control host and device ends
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
	$display("Error %0t: got %h expected %h", $time, a, e); end end
module tb
	import sci_pkg::*;
;
	logic hclk, hreadyout, hresp, tx_run, rx_run, cs_strobe;
	logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fs2_tick = 1'b0, fault = 1'b0;
	logic activity = 1'b0, nonaudio = 1'b0, burst_evt = 1'b0, slip = 1'b0, emph = 1'b0;
	logic dir = 1'b0;
	logic [1:0] htrans = 2'h0, strap = 2'h2;
	logic [3:0] rate = 4'h0, aux_in = 4'h0, fcnt = 4'h0;
	logic [3:0] aux_out, aux_oe, cs_index;
	logic [7:0] cs_byte;
	logic [15:0] q;
	logic [15:0] pc = 16'h5A3C;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [47:0] chanstat = 48'h1234_5678_9ABC;
	int num_errors = 0, cmp_count = 0, n_strobe = 0;

	sci_if sci_if_i ();
	sci_host sci_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(sci_if_i));
	sci_device sci_device_i (.hclk(hclk), .hresetn(hresetn), .link(sci_if_i),
		.chip_addr_strap(strap), .fs2_tick(fs2_tick), .receive_fault_flag(fault),
		.input_activity(activity), .rate_code(rate), .chanstat(chanstat),
		.nonaudio_flag(nonaudio), .burst_info_evt(burst_evt), .slip_evt(slip),
		.emphasis_flag(emph), .burst_pc(pc), .port_direction_sel(dir), .aux_port_in(aux_in),
		.aux_port_out(aux_out), .aux_port_oe(aux_oe), .tx_run(tx_run), .rx_run(rx_run),
		.cs_wr_byte(cs_byte), .cs_wr_index(cs_index), .cs_wr_strobe(cs_strobe));
	sci_link_monitor sci_link_monitor_i (.hclk(hclk), .hresetn(hresetn),
		.serial_shift_clock(sci_if_i.serial_shift_clock),
		.serial_enable(sci_if_i.serial_enable), .serial_in(sci_if_i.serial_in),
		.serial_out_oe(sci_if_i.serial_out_oe), .irq_n(sci_if_i.irq_n));

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// two ticks per fs period of 32 cycles
	always @(posedge hclk) begin
		fcnt <= fcnt + 4'h1;
		fs2_tick <= (fcnt == 4'hF);
	end
	always @(posedge hclk) if (cs_strobe === 1'b1) n_strobe++;

	function automatic logic [15:0] wd(input logic [3:0] c, input logic [7:0] d);
		return {d, c, 2'b00, strap};
	endfunction : wd

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb

	task automatic frm(input logic [7:0] b, input logic [15:0] w, output logic [15:0] rd);
		logic [31:0] r;
		ahb(1'b1, REG_BUS_ADDR, {24'h00_0000, b}, r);
		ahb(1'b1, REG_WORD, {16'h0000, w}, r);
		ahb(1'b1, REG_GO, 32'h0000_0001, r);
		do ahb(1'b0, REG_STATUS, 32'h0000_0000, r);
		while (r[0] !== 1'b0);
		ahb(1'b0, REG_READ, 32'h0000_0000, r);
		rd = r[15:0];
	endtask : frm

	task automatic t_port();
		@(posedge hclk) dir <= 1'b0;
		frm(BUS_FUNC_WR, wd(CMD_AUX_PORT, 8'h50), q);
		`CHK(aux_out, 4'h5)
		`CHK(aux_oe, 4'hF)
		frm(BUS_FUNC_WR, {8'hC0, CMD_AUX_PORT, 2'b00, ~strap}, q);
		`CHK(aux_out, 4'h5)
		frm(BUS_FUNC_WR, wd(CMD_AUX_PORT, 8'hC0) | 16'h0004, q);
		`CHK(aux_out, 4'h5)
		@(posedge hclk) dir <= 1'b1;
		repeat (4) @(posedge hclk);
		`CHK(aux_oe, 4'h0)
	endtask : t_port

	task automatic t_read();
		@(posedge hclk) aux_in <= 4'h9;
		rate <= 4'h6;
		repeat (4) @(posedge hclk);
		frm(BUS_RATE_RD, 16'h0000, q);
		`CHK(q, 16'h0069)
		frm(BUS_CS_RD, 16'h0000, q);
		`CHK(q, chanstat[15:0])
		frm(BUS_PC_RD, 16'h0000, q);
		`CHK(q, pc)
	endtask : t_read

	task automatic t_level();
		logic [31:0] r;
		frm(BUS_FUNC_WR, wd(CMD_IRQ_SEL, 8'h04), q);
		frm(BUS_EVT_RD, 16'h0000, q);
		@(posedge hclk) fault <= 1'b1;
		repeat (10) @(posedge hclk);
		`CHK(sci_if_i.irq_n, 1'b1)
		@(posedge hclk) rate <= 4'h3;
		repeat (60) @(posedge hclk);
		`CHK(sci_if_i.irq_n, 1'b0)
		ahb(1'b0, REG_STATUS, 32'h0000_0000, r);
		`CHK(r[1], 1'b1)
		frm(BUS_EVT_RD, 16'h0000, q);
		`CHK(q, 16'h0500)
		`CHK(sci_if_i.irq_n, 1'b1)
		frm(BUS_EVT_RD, 16'h0000, q);
		`CHK(q, 16'h0100)
		@(posedge hclk) fault <= 1'b0;
	endtask : t_level

	task automatic t_pulse();
		int w;
		frm(BUS_FUNC_WR, wd(CMD_SYSTEM, 8'h08), q);
		frm(BUS_FUNC_WR, wd(CMD_IRQ_SEL, 8'h40), q);
		@(posedge hclk) slip <= 1'b1;
		@(posedge hclk) slip <= 1'b0;
		w = 0;
		repeat (100) begin
			@(posedge hclk);
			if (sci_if_i.irq_n === 1'b0) w++;
		end
		`CHK(w >= 16 && w <= 48, 1'b1)
		`CHK(sci_if_i.irq_n, 1'b1)
	endtask : t_pulse

	task automatic t_dis();
		frm(BUS_RATE_RD, 16'h0000, q);
		`CHK(q, 16'h0039)
		frm(BUS_FUNC_WR, wd(CMD_SYSTEM, 8'h02), q);
		frm(BUS_RATE_RD, 16'h0000, q);
		`CHK(q, 16'hFFFF)
		frm(BUS_FUNC_WR, wd(CMD_SYSTEM, 8'h30), q);
		`CHK({tx_run, rx_run}, 2'b11)
	endtask : t_dis

	task automatic t_cs();
		n_strobe = 0;
		frm(BUS_CS_WR, wd(4'h3, 8'hA5), q);
		`CHK(n_strobe, 1)
		`CHK(cs_byte, 8'hA5)
		`CHK(cs_index, 4'h3)
	endtask : t_cs

	task automatic summarize();
		if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		t_port();
		t_read();
		t_level();
		t_pulse();
		t_dis();
		t_cs();
		summarize();
	end

	initial begin
		#1_000_000;
		num_errors++;
		summarize();
	end
endmodule : tb
`default_nettype wire
